// file: shared/mosf_pkg.sv
package mosf_pkg;

  // ==========================================================================
  // bus layout
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_VA_WIN = 5'h04;
  localparam logic [4:0] OFS_ZV_WIN = 5'h08;
  localparam logic [4:0] OFS_CAP_RATIO = 5'h0c;
  localparam logic [4:0] OFS_CAP_VALUE = 5'h10;
  localparam logic [4:0] OFS_FLAGS = 5'h14;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h1c;

  // ==========================================================================
  // control fields
  localparam int CTRL_CRIT_LSB = 0;
  localparam int CTRL_CAPTYPE_BIT = 2;

  // attainment criterion codes, code 3 is refused
  typedef enum logic [1:0] {
    MOSF_CRIT_FB = 2'h0,
    MOSF_CRIT_CMD = 2'h1,
    MOSF_CRIT_BOTH = 2'h2
  } mosf_crit_e;

  // speed cap derivation
  localparam logic CAP_RATIO = 1'h0;
  localparam logic CAP_VALUE = 1'h1;

  // ==========================================================================
  // reset values and legal ranges
  localparam logic [1:0] CRIT_RST = 2'h2;
  localparam logic CAPTYPE_RST = 1'h0;
  localparam logic [7:0] VA_WIN_RST = 8'h1e;
  localparam logic [7:0] VA_WIN_MIN = 8'h01;
  localparam logic [7:0] VA_WIN_MAX = 8'hc8;
  localparam logic [7:0] ZV_WIN_RST = 8'h0f;
  localparam logic [7:0] ZV_WIN_MAX = 8'hc8;
  localparam logic [6:0] RATIO_RST = 7'h32;
  localparam logic [6:0] RATIO_MIN = 7'h01;
  localparam logic [6:0] RATIO_MAX = 7'h64;
  localparam logic [21:0] CAP_RST = 22'h0003e8;
  localparam logic [21:0] CAP_MIN = 22'h000001;
  localparam logic [21:0] CAP_MAX = 22'h3d0900;
  localparam logic [6:0] PERCENT_FULL = 7'h64;

  // ==========================================================================
  // carriers
  localparam int SPEED_W = 32;
  localparam int NUM_FLAGS = 8;

  typedef struct packed {
    logic signed [31:0] fb_speed;     // feedback speed, r/min
    logic signed [31:0] cmd_speed;    // command speed, r/min
    logic signed [31:0] target_speed; // profile target speed, r/min
    logic [31:0] op_speed_hz;         // operation data operating speed
    logic signed [31:0] run_speed_hz; // present operating speed
    logic internal_profile;           // internally generated profile
    logic torque_limit_active;
    logic torque_at_limit;
    logic speed_limit_active;
    logic overload_torque;            // torque at overload alarm level
    logic home_fast_done;             // pulse
    logic home_done;                  // pulse
    logic preset_done;                // pulse
    logic op_start;                   // pulse
    logic buffer_writing;
    logic control_power;
    logic main_power;
    logic excite_cmd;
    logic stop_input;
    logic clear_input;
    logic alarm;
    logic home_running;
    logic [3:0] tool_busy;            // remote, io test, writing, restore
    logic [5:0] maint_busy;           // fieldbus maintenance commands
  } mosf_drive_s;

  typedef struct packed {
    logic direct_command_ready_flag;
    logic direct_buffer_busy_flag;
    logic overload_warning_flag;
    logic zero_speed_flag;
    logic homing_complete_flag;
    logic speed_limited_flag;
    logic torque_limited_flag;
    logic speed_attained_flag;
  } mosf_flags_s;

endpackage : mosf_pkg

// file: hdl/mosf_status_flags.sv
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - criterion 0: feedback within window around command
// - criterion 1: command speed equals target speed
// - criterion codes 0,1,2; reset value 2
// - torque flag only while torque limiting active
// - speed flag when clamped at or above cap
// - cap type: 0 ratio, 1 value; reset 0
// - ratio cap: percent of operating speed, 1-100
// - value cap: 1 to 4,000,000 Hz, reset 1000
// - homing set by fast home, home, preset
// - homing cleared at power-up and operation start
// - zero speed when abs feedback within window
// - overload warning at overload torque level
// - buffer busy while buffer being written
// - ready needs power, excitation, no stop/clear/alarm/home
// - ready low during setup tool activities
// - ready low during fieldbus maintenance commands
module mosf_status_flags (
  input wire logic core_clk,                       // 20 MHz control clock
  input wire logic reset,                          // sync, active high
  input wire logic clk_en,                         // freezes all state when low
  input wire mosf_pkg::mosf_drive_s drive,         // drive status inputs
  input wire logic [4:0] avs_address,              // byte address
  input wire logic avs_read,                       // read request
  input wire logic avs_write,                      // write request
  input wire logic [31:0] avs_writedata,           // write data
  input wire logic [3:0] avs_byteenable,           // byte lanes
  output logic [31:0] avs_readdata,                // read data
  output logic avs_waitrequest,                    // stall
  output mosf_pkg::mosf_flags_s flags,             // status flags
  output logic irq                                 // level interrupt
);

  // ==========================================================================
  // elaboration checks
  if (mosf_pkg::NUM_FLAGS != $bits(mosf_pkg::mosf_flags_s)) begin : g_chk
    $error("flag count does not match flag carrier");
  end

  // ==========================================================================
  // bus handshake
  logic wait_q;
  logic [31:0] rdata_q;
  logic take;
  logic wr_take;
  logic [31:0] rdata_d;

  // one stall cycle per access, then release
  assign take = (avs_read | avs_write) & ~wait_q;
  assign wr_take = take & avs_write & clk_en;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_q <= 1'b1;
    end else if (clk_en) begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
    end
  end

  // ==========================================================================
  // configuration registers
  logic [1:0] crit_q;
  logic captype_q;
  logic [7:0] va_win_q;
  logic [7:0] zv_win_q;
  logic [6:0] ratio_q;
  logic [21:0] cap_q;
  logic [7:0] mask_q;
  logic [7:0] stat_q;
  logic [31:0] wd;
  logic [31:0] be_mask;

  // zero the byte lanes that are not enabled
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb begin
    wd = avs_writedata & be_mask;
  end

  // control word, illegal codes refused
  always_ff @(posedge core_clk) begin
    if (reset) begin
      crit_q <= mosf_pkg::CRIT_RST;
      captype_q <= mosf_pkg::CAPTYPE_RST;
    end else if (wr_take && avs_address == mosf_pkg::OFS_CTRL && avs_byteenable[0]) begin
      if (wd[mosf_pkg::CTRL_CRIT_LSB +: 2] != 2'h3) begin
        crit_q <= wd[mosf_pkg::CTRL_CRIT_LSB +: 2];
      end
      captype_q <= wd[mosf_pkg::CTRL_CAPTYPE_BIT];
    end
  end

  // speed windows, out of range writes ignored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      va_win_q <= mosf_pkg::VA_WIN_RST;
      zv_win_q <= mosf_pkg::ZV_WIN_RST;
    end else if (wr_take && avs_byteenable[0]) begin
      if (avs_address == mosf_pkg::OFS_VA_WIN && wd[31:8] == 24'h000000 &&
          wd[7:0] >= mosf_pkg::VA_WIN_MIN && wd[7:0] <= mosf_pkg::VA_WIN_MAX) begin
        va_win_q <= wd[7:0];
      end
      if (avs_address == mosf_pkg::OFS_ZV_WIN && wd[31:8] == 24'h000000 &&
          wd[7:0] <= mosf_pkg::ZV_WIN_MAX) begin
        zv_win_q <= wd[7:0];
      end
    end
  end

  // speed cap settings, whole-word writes only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ratio_q <= mosf_pkg::RATIO_RST;
      cap_q <= mosf_pkg::CAP_RST;
    end else if (wr_take && avs_byteenable == 4'hf) begin
      if (avs_address == mosf_pkg::OFS_CAP_RATIO && wd[31:7] == 25'h0000000 &&
          wd[6:0] >= mosf_pkg::RATIO_MIN && wd[6:0] <= mosf_pkg::RATIO_MAX) begin
        ratio_q <= wd[6:0];
      end
      if (avs_address == mosf_pkg::OFS_CAP_VALUE && wd[31:22] == 10'h000 &&
          wd[21:0] >= mosf_pkg::CAP_MIN && wd[21:0] <= mosf_pkg::CAP_MAX) begin
        cap_q <= wd[21:0];
      end
    end
  end

  // ==========================================================================
  // flag evaluation
  logic [31:0] fb_abs;
  logic [31:0] run_abs;
  logic signed [32:0] fb_err;
  logic [32:0] fb_err_abs;
  logic fb_in_window;
  logic cmd_match;
  logic va_d;
  logic [38:0] run_scaled;
  logic [38:0] cap_scaled;
  logic at_cap;
  logic ready_d;
  logic homing_q;
  mosf_pkg::mosf_flags_s flags_d;
  mosf_pkg::mosf_flags_s flags_q;

  // magnitudes and window distance
  always_comb begin
    fb_abs = drive.fb_speed[31] ? 32'(-drive.fb_speed) : 32'(drive.fb_speed);
    run_abs = drive.run_speed_hz[31] ? 32'(-drive.run_speed_hz) : 32'(drive.run_speed_hz);
    fb_err = 33'(drive.fb_speed) - 33'(drive.cmd_speed);
    fb_err_abs = fb_err[32] ? 33'(-fb_err) : 33'(fb_err);
  end

  assign fb_in_window = fb_err_abs <= 33'(va_win_q);
  assign cmd_match = drive.internal_profile & (drive.cmd_speed == drive.target_speed);

  // attainment by criterion
  always_comb begin
    va_d = 1'b0;
    unique case (crit_q)
      mosf_pkg::MOSF_CRIT_FB: va_d = fb_in_window;
      mosf_pkg::MOSF_CRIT_CMD: va_d = cmd_match;
      mosf_pkg::MOSF_CRIT_BOTH: va_d = fb_in_window & cmd_match;
      default: va_d = 1'b0;
    endcase
  end

  // cap compare without division: run*100 >= op*ratio
  always_comb begin
    run_scaled = 39'(run_abs) * 39'(mosf_pkg::PERCENT_FULL);
    cap_scaled = 39'(drive.op_speed_hz) * 39'(ratio_q);
  end

  assign at_cap = (captype_q == mosf_pkg::CAP_RATIO) ? (run_scaled >= cap_scaled) :
                  (run_abs >= 32'(cap_q));

  // readiness for direct commands
  assign ready_d = drive.control_power & drive.main_power & drive.excite_cmd &
                   ~drive.stop_input & ~drive.clear_input & ~drive.alarm &
                   ~drive.home_running &
                   (drive.tool_busy == 4'h0) &
                   (drive.maint_busy == 6'h00);

  // homing complete: completions set, starts clear, set wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      homing_q <= 1'b0;
    end else if (clk_en) begin
      if (drive.home_fast_done | drive.home_done | drive.preset_done) begin
        homing_q <= 1'b1;
      end else if (drive.op_start) begin
        homing_q <= 1'b0;
      end
    end
  end

  // gather flags
  always_comb begin
    flags_d.speed_attained_flag = va_d;
    flags_d.torque_limited_flag = drive.torque_limit_active & drive.torque_at_limit;
    flags_d.speed_limited_flag = drive.speed_limit_active & at_cap;
    flags_d.homing_complete_flag = homing_q;
    flags_d.zero_speed_flag = fb_abs <= 32'(zv_win_q);
    flags_d.overload_warning_flag = drive.overload_torque;
    flags_d.direct_buffer_busy_flag = drive.buffer_writing;
    flags_d.direct_command_ready_flag = ready_d;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_q <= '0;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

  // ==========================================================================
  // interrupts: rising flag sets sticky bit, write one clears
  logic [7:0] rise;
  logic [7:0] clr;
  logic irq_q;

  assign clr = (wr_take && avs_address == mosf_pkg::OFS_IRQ_STAT && avs_byteenable[0]) ?
               wd[7:0] : 8'h00;

  for (genvar i = 0; i < mosf_pkg::NUM_FLAGS; i++) begin : g_irq
    assign rise[i] = flags_d[i] & ~flags_q[i];
    always_ff @(posedge core_clk) begin
      if (reset) begin
        stat_q[i] <= 1'b0;
      end else if (clk_en) begin
        if (rise[i]) begin
          stat_q[i] <= 1'b1; // set wins over clear
        end else if (clr[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_q <= 8'h00;
    end else if (wr_take && avs_address == mosf_pkg::OFS_IRQ_MASK && avs_byteenable[0]) begin
      mask_q <= wd[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign irq = irq_q;

  // ==========================================================================
  // read mux, unmapped reads zero
  always_comb begin
    rdata_d = 32'h00000000;
    unique case (avs_address)
      mosf_pkg::OFS_CTRL: rdata_d = {29'h00000000, captype_q, crit_q};
      mosf_pkg::OFS_VA_WIN: rdata_d = {24'h000000, va_win_q};
      mosf_pkg::OFS_ZV_WIN: rdata_d = {24'h000000, zv_win_q};
      mosf_pkg::OFS_CAP_RATIO: rdata_d = {25'h0000000, ratio_q};
      mosf_pkg::OFS_CAP_VALUE: rdata_d = {10'h000, cap_q};
      mosf_pkg::OFS_FLAGS: rdata_d = {24'h000000, flags_q};
      mosf_pkg::OFS_IRQ_STAT: rdata_d = {24'h000000, stat_q};
      mosf_pkg::OFS_IRQ_MASK: rdata_d = {24'h000000, mask_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else if (clk_en && avs_read && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ==========================================================================
  // assertions
  sequence s_home_event;
    clk_en && (drive.home_fast_done || drive.home_done || drive.preset_done);
  endsequence

  sequence s_start_only;
    clk_en && drive.op_start && !drive.home_fast_done && !drive.home_done &&
      !drive.preset_done;
  endsequence

  a_va_fb_window: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && crit_q == 2'h0) |=> (flags.speed_attained_flag == $past(fb_in_window)))
    else $error("speed attained wrong under feedback criterion");

  a_va_cmd_match: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && crit_q == 2'h1 && drive.internal_profile &&
     drive.cmd_speed == drive.target_speed) |=> flags.speed_attained_flag)
    else $error("speed attained missing on command match");

  a_va_both_need: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && crit_q == 2'h2 && !(fb_in_window && cmd_match)) |=>
      !flags.speed_attained_flag)
    else $error("speed attained set without both conditions");

  a_crit_legal: assert property (@(posedge core_clk) disable iff (reset)
    crit_q != 2'h3)
    else $error("illegal attainment criterion stored");

  a_trq_gated: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !drive.torque_limit_active) |=> !flags.torque_limited_flag)
    else $error("torque flag set while limiting inactive");

  a_spd_value_cap: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && drive.speed_limit_active && captype_q && run_abs >= 32'(cap_q)) |=>
      flags.speed_limited_flag)
    else $error("speed limited missing at value cap");

  a_spd_ratio_cap: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !captype_q && run_scaled < cap_scaled) |=> !flags.speed_limited_flag)
    else $error("speed limited set below ratio cap");

  a_home_set: assert property (@(posedge core_clk) disable iff (reset)
    s_home_event |=> ##1 flags.homing_complete_flag)
    else $error("homing complete not set after completion");

  a_home_clear: assert property (@(posedge core_clk) disable iff (reset)
    s_start_only |=> !homing_q ##1 !flags.homing_complete_flag)
    else $error("homing complete not cleared by start");

  a_zero_speed: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && fb_abs > 32'(zv_win_q)) |=> !flags.zero_speed_flag)
    else $error("zero speed set outside window");

  a_overload: assert property (@(posedge core_clk) disable iff (reset)
    clk_en |=> flags.overload_warning_flag == $past(drive.overload_torque))
    else $error("overload warning does not follow torque");

  a_buffer_busy: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && drive.buffer_writing) |=> flags.direct_buffer_busy_flag)
    else $error("buffer busy missing while writing");

  a_ready_block: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && (drive.alarm || drive.stop_input || drive.clear_input ||
     drive.home_running || !drive.excite_cmd)) |=> !flags.direct_command_ready_flag)
    else $error("ready set while blocked");

  a_ready_tool: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && drive.tool_busy != 4'h0) |=> !flags.direct_command_ready_flag)
    else $error("ready set during setup tool activity");

  a_ready_maint: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && drive.maint_busy != 6'h00) |=> !flags.direct_command_ready_flag)
    else $error("ready set during maintenance command");

  a_bus_release: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule : mosf_status_flags

// file: tb/mosf_host_model.sv
`timescale 1ns/1ns
// ==========================================================================
// host controller: starts an operation only once ready is seen
module mosf_host_model (
  input wire logic core_clk, // control clock
  input wire logic reset,    // sync reset
  input wire logic ready,    // direct command ready flag
  input wire logic go,       // bench asks for a start
  output logic start         // one-cycle operation start
);
  logic pend_q;

  // hold a start request back until the drive reports ready
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_q <= 1'b0;
      start <= 1'b0;
    end else begin
      start <= (pend_q | go) & ready;
      pend_q <= (pend_q | go) & ~ready;
    end
  end
endmodule : mosf_host_model

// file: tb/testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic core_clk, reset, clk_en, avs_read, avs_write, go, host_start, irq, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, e, r;
  logic [3:0] avs_byteenable;
  mosf_pkg::mosf_drive_s drv, drv_in, base;
  mosf_pkg::mosf_flags_s flags_o;
  logic [31:0] expq[$];
  int error_cnt = 0, compares = 0, cyc = 0, i, c;
  integer seed;
  logic [1:0] crit;
  logic cap_t;
  longint va_win, zv_win, ratio, cap;
  logic [4:0] ta[10] = '{5'h00, 5'h04, 5'h04, 5'h04, 5'h08, 5'h08, 5'h0c, 5'h0c, 5'h10, 5'h10};
  logic [31:0] tv[10] = '{32'h3, 32'h0, 32'hc9, 32'hc8, 32'hc9, 32'h0, 32'h65, 32'h64,
    32'h3d0901, 32'h3d0900};
  logic [31:0] te[10] = '{32'h2, 32'h1e, 32'h1e, 32'hc8, 32'h0f, 32'h0, 32'h32, 32'h64,
    32'h3e8, 32'h3d0900};

  // ==========================================================================
  // clock, start pulse merge and instances
  always #25 core_clk = ~core_clk;
  always_comb begin
    drv_in = drv;
    drv_in.op_start = host_start;
  end
  mosf_status_flags dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .drive(drv_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flags(flags_o), .irq(irq));
  mosf_host_model host (.core_clk(core_clk), .reset(reset),
    .ready(flags_o.direct_command_ready_flag), .go(go), .start(host_start));

  // ==========================================================================
  // bus tasks, expected flag word, stimulus
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr

  task automatic rd(logic [4:0] a, logic [31:0] x);
    @(posedge core_clk);
    expq.push_back(x);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask : rd

  function automatic logic [31:0] expf(mosf_pkg::mosf_drive_s d, logic h);
    longint df, fa, ra;
    logic vf, vc, va, sl, rdy;
    df = longint'(d.fb_speed) - longint'(d.cmd_speed);
    df = df < 0 ? -df : df;
    fa = d.fb_speed < 0 ? -longint'(d.fb_speed) : longint'(d.fb_speed);
    ra = d.run_speed_hz < 0 ? -longint'(d.run_speed_hz) : longint'(d.run_speed_hz);
    vf = df <= va_win;
    vc = d.internal_profile && d.cmd_speed == d.target_speed;
    va = crit == 2'h0 ? vf : (crit == 2'h1 ? vc : vf & vc);
    sl = cap_t ? ra >= cap : ra * 100 >= longint'(d.op_speed_hz) * ratio;
    rdy = d.control_power & d.main_power & d.excite_cmd & ~d.stop_input & ~d.clear_input
      & ~d.alarm & ~d.home_running & ~|d.tool_busy & ~|d.maint_busy;
    return {24'h0, rdy, d.buffer_writing, d.overload_torque, fa <= zv_win, h,
      d.speed_limit_active & sl, d.torque_limit_active & d.torque_at_limit, va};
  endfunction : expf

  task automatic rnd_drive();
    mosf_pkg::mosf_drive_s d;
    r = $random(seed);
    d = '0;
    d.cmd_speed = $random(seed) % 300;
    d.fb_speed = r[0] ? $random(seed) % 24 : d.cmd_speed + $random(seed) % 40;
    d.target_speed = d.cmd_speed + r[1];
    d.op_speed_hz = $unsigned($random(seed)) % 2000;
    d.run_speed_hz = $random(seed) % 2500;
    {d.internal_profile, d.torque_limit_active, d.torque_at_limit, d.speed_limit_active,
      d.overload_torque, d.buffer_writing} = r[7:2];
    {d.control_power, d.main_power, d.excite_cmd, d.stop_input, d.clear_input, d.alarm,
      d.home_running} = r[10] ? 7'h70 : r[17:11];
    d.tool_busy = r[10] ? 4'h0 : r[21:18];
    d.maint_busy = r[10] ? 6'h0 : r[27:22];
    drv <= d;
  endtask : rnd_drive

  task automatic final_report();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // ==========================================================================
  // read monitor and hang guard
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      `CHK(avs_readdata, e)
    end
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    core_clk = 1'b0; reset = 1'b1; clk_en = 1'b1; drv = '0; go = 1'b0; avs_read = 1'b0;
    avs_write = 1'b0; avs_address = 5'h00; avs_writedata = 32'h0; avs_byteenable = 4'hf;
    seed = 32'hdc34e4bb;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(5'h00, 32'h2);
    rd(5'h04, 32'h1e);
    rd(5'h08, 32'h0f);
    rd(5'h0c, 32'h32);
    rd(5'h10, 32'h3e8);
    rd(5'h03, 32'h0);
    // out-of-range settings kept out, boundary settings taken
    for (i = 0; i < 10; i++) begin
      wr(ta[i], tv[i]);
      rd(ta[i], te[i]);
    end
    // every criterion code with both cap types against random drive states
    for (c = 0; c < 6; c++) begin
      crit = 2'(c % 3);
      cap_t = 1'(c / 3);
      va_win = 1 + $unsigned($random(seed)) % 200;
      zv_win = $unsigned($random(seed)) % 201;
      ratio = 1 + $unsigned($random(seed)) % 100;
      cap = 1 + $unsigned($random(seed)) % 3000;
      wr(5'h00, {29'h0, cap_t, crit});
      wr(5'h04, 32'(va_win));
      wr(5'h08, 32'(zv_win));
      wr(5'h0c, 32'(ratio));
      wr(5'h10, 32'(cap));
      for (i = 0; i < 16; i++) begin
        rnd_drive();
        repeat (3) @(posedge core_clk);
        rd(5'h14, expf(drv, 1'b0));
      end
    end
    // a ratio write on one byte lane only is refused
    avs_byteenable <= 4'h1;
    wr(5'h0c, 32'h0a);
    rd(5'h0c, 32'(ratio));
    avs_byteenable <= 4'hf;
    // homing sources set the flag, a host start clears it
    base = '0;
    {base.control_power, base.main_power, base.excite_cmd} = 3'h7;
    drv <= base;
    for (i = 0; i < 3; i++) begin
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(5'h14, expf(base, 1'b0));
      {drv.home_fast_done, drv.home_done, drv.preset_done} <= 3'h4 >> i;
      @(posedge core_clk);
      {drv.home_fast_done, drv.home_done, drv.preset_done} <= 3'h0;
      repeat (3) @(posedge core_clk);
      rd(5'h14, expf(base, 1'b1));
    end
    // a start held back while stopped, then released
    drv.stop_input <= 1'b1;
    repeat (2) @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(5'h14, expf(drv, 1'b1));
    drv.stop_input <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(5'h14, expf(base, 1'b0));
    // completion landing on the same edge as a start
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    drv.home_done <= 1'b1;
    @(posedge core_clk);
    drv.home_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(5'h14, expf(base, 1'b1));
    // buffer busy raises a sticky, maskable interrupt
    wr(5'h1c, 32'h40);
    wr(5'h18, 32'hff);
    rd(5'h18, 32'h0);
    `CHK(irq, 1'b0)
    drv.buffer_writing <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(irq, 1'b1)
    rd(5'h18, 32'h40);
    drv.buffer_writing <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(irq, 1'b1)
    wr(5'h18, 32'h40);
    repeat (4) @(posedge core_clk);
    `CHK(irq, 1'b0)
    wr(5'h1c, 32'h0);
    drv.buffer_writing <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(irq, 1'b0)
    rd(5'h18, 32'h40);
    // clock enable low freezes the flag register
    clk_en <= 1'b0;
    drv.overload_torque <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(flags_o.overload_warning_flag, 1'b0)
    clk_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK(flags_o.overload_warning_flag, 1'b1)
    repeat (4) @(posedge core_clk);
    final_report();
  end
endmodule : testbench
